// file: pmt_top.sv
// Functional notes
// - Timer ticks come from the system clock divided by four, then the prescaler.
// - Prescale select 00 divides by 1, 01 by 4, 1x by 16.
// - Count register is compared against the period register every cycle.
// - On an increment while count equals period, count reloads zero instead.
// - Every match advances the postscaler counter by one, or wraps it to zero when it equals the select value.
// - Postscale select value n gives one output per n+1 matches.
// - Each postscaler output sets the period interrupt flag.
// - Count and period registers are fully readable and writable.
// - Any reset clears count and sets period to all ones.
// - Control bit 2 runs the timer when one, stops it when zero.
// - Count write, control write and reset clear prescaler and postscaler.
// - Writing the control register leaves the count value untouched.
// - The only unimplemented control bit, bit 7, reads zero and ignores writes.
module pmt_top
    import pmt_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [DATA_W-1:0] REG_RDATA_O,
    output logic IRQ_O
);

    logic [1:0] instr_cnt_q;
    logic instr_tick;
    logic [7:0] count_q;
    logic [7:0] period_q;
    logic [CTRL_IMPL_W-1:0] control_q;
    logic flag_q;
    logic mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic wr_count;
    logic wr_period;
    logic wr_control;
    logic wr_mask;
    logic rd_status;
    logic run;
    logic pre_tick;
    logic pre_pulse;
    logic [3:0] pre_cnt;
    logic match_now;
    logic match_evt;
    logic post_pulse;
    logic [3:0] post_cnt;
    logic scaler_clr;

    // Address decode; strobes are single cycle and never overlap
    assign wr_count = REG_WR_I && (REG_ADDR_I == ADDR_COUNT);
    assign wr_period = REG_WR_I && (REG_ADDR_I == ADDR_PERIOD);
    assign wr_control = REG_WR_I && (REG_ADDR_I == ADDR_CONTROL);
    assign wr_mask = REG_WR_I && (REG_ADDR_I == ADDR_MASK);
    assign rd_status = REG_RD_I && (REG_ADDR_I == ADDR_STATUS);

    // Instruction clock enable; free running so timer phase does not depend on writes
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            instr_cnt_q <= 2'h0;
        else if (instr_cnt_q == INSTR_LAST)
            instr_cnt_q <= 2'h0;
        else
            instr_cnt_q <= instr_cnt_q + 2'h1;
    end

    assign instr_tick = (instr_cnt_q == INSTR_LAST);

    // Run gating and scaler clearing
    assign run = control_q[RUN_BIT];
    assign pre_tick = instr_tick && run;
    assign scaler_clr = wr_count || wr_control;

    pmt_prescaler u_pre (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .clr_i(scaler_clr),
        .tick_i(pre_tick),
        .sel_i(control_q[PRE_SEL_MSB:PRE_SEL_LSB]),
        .pulse_o(pre_pulse),
        .cnt_o(pre_cnt)
    );

    // Comparator runs every cycle; a match only counts when the increment consumes it
    assign match_now = (count_q == period_q);
    assign match_evt = pre_pulse && match_now;

    pmt_postscaler u_post (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .clr_i(scaler_clr),
        .match_i(match_evt),
        .sel_i(control_q[POST_SEL_MSB:POST_SEL_LSB]),
        .pulse_o(post_pulse),
        .cnt_o(post_cnt)
    );

    // Count register; a software write beats a simultaneous increment
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            count_q <= COUNT_RST;
        else if (wr_count)
            count_q <= REG_WDATA_I;
        else if (pre_pulse)
        begin
            if (match_now)
                count_q <= COUNT_RST;
            else
                count_q <= count_q + 8'h01;
        end
    end

    // Period register
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            period_q <= PERIOD_RST;
        else if (wr_period)
            period_q <= REG_WDATA_I;
    end

    // Control register; top bit is not stored so it can never read back
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            control_q <= CONTROL_RST;
        else if (wr_control)
            control_q <= REG_WDATA_I[CTRL_IMPL_W-1:0];
    end

    // Interrupt flag; a set in the cycle of the clearing read wins
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            flag_q <= 1'b0;
        else if (post_pulse)
            flag_q <= 1'b1;
        else if (rd_status)
            flag_q <= 1'b0;
    end

    // Interrupt mask
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            mask_q <= 1'b0;
        else if (wr_mask)
            mask_q <= REG_WDATA_I[FLAG_BIT];
    end

    // Level interrupt, built only from flops
    assign IRQ_O = flag_q && mask_q;

    // Read data valid only in the cycle after the read strobe
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
            rdata_q <= READ_ZERO;
        else if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                ADDR_COUNT: rdata_q <= count_q;
                ADDR_PERIOD: rdata_q <= period_q;
                ADDR_CONTROL: rdata_q <= {1'b0, control_q};
                ADDR_STATUS: rdata_q <= {7'h00, flag_q};
                ADDR_MASK: rdata_q <= {7'h00, mask_q};
                default: rdata_q <= READ_ZERO;
            endcase
        end
        else
            rdata_q <= READ_ZERO;
    end

    assign REG_RDATA_O = rdata_q;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    a_count_step: assert property ((pre_pulse && !match_now && !wr_count)
        |=> (count_q == $past(count_q) + 8'h01))
        else $error("count did not increment on a prescaler pulse");
    a_instr_spacing: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
        else $error("instruction tick not every fourth cycle");
    a_count_wrap: assert property ((pre_pulse && match_now && !wr_count)
        |=> (count_q == 8'h00))
        else $error("count did not wrap to zero after a match");
    a_stop_hold: assert property ((!run && !wr_count) |=> $stable(count_q))
        else $error("stopped timer changed its count");
    a_scaler_clear: assert property (scaler_clr |=> (pre_cnt == 4'h0 && post_cnt == 4'h0))
        else $error("scalers not cleared by a register write");
    a_ctrl_keep_count: assert property (wr_control |=> $stable(count_q))
        else $error("control write disturbed the count");
    a_flag_set: assert property (post_pulse |=> flag_q)
        else $error("postscaler output did not set the flag");
    a_flag_sticky: assert property ((flag_q && !rd_status) |=> flag_q)
        else $error("flag dropped without a status read");
    a_ctrl_msb_zero: assert property ((REG_RD_I && REG_ADDR_I == ADDR_CONTROL)
        |=> (REG_RDATA_O[7] == 1'b0))
        else $error("unimplemented control bit read as one");
    a_period_write: assert property (wr_period |=> (period_q == $past(REG_WDATA_I)))
        else $error("period write not stored");
    a_reset_values: assert property (@(posedge SYS_CLK_I) disable iff (1'b0)
        !RESET_N_I |=> (count_q == 8'h00 && period_q == 8'hFF))
        else $error("reset values wrong");

    c_wrap: cover property (pre_pulse && match_now);
    c_post_fire: cover property (post_pulse && control_q[POST_SEL_MSB:POST_SEL_LSB] == 4'hF);
    c_irq: cover property (IRQ_O ##1 rd_status);
    c_set_clear_race: cover property (post_pulse && rd_status);

endmodule

// file: pmt_pkg.sv
package pmt_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register addresses
    localparam logic [3:0] ADDR_COUNT = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h1;
    localparam logic [3:0] ADDR_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_MASK = 4'h4;

    // Reset values
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [6:0] CONTROL_RST = 7'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Control register fields
    localparam int CTRL_IMPL_W = 7;
    localparam int POST_SEL_MSB = 6;
    localparam int POST_SEL_LSB = 3;
    localparam int RUN_BIT = 2;
    localparam int PRE_SEL_MSB = 1;
    localparam int PRE_SEL_LSB = 0;

    // Status and mask register fields
    localparam int FLAG_BIT = 0;

    // Prescaler select codes and terminal counts
    localparam logic [1:0] PRE_SEL_DIV1 = 2'h0;
    localparam logic [1:0] PRE_SEL_DIV4 = 2'h1;
    localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
    localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
    localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;

    // Instruction clock is the system clock divided by four
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

endpackage

// file: pmt_prescaler.sv
module pmt_prescaler
    import pmt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic tick_i,
    input wire logic [1:0] sel_i,
    output logic pulse_o,
    output logic [3:0] cnt_o
);

    logic [3:0] cnt_q;
    logic [3:0] last;

    // Terminal count for the selected ratio; 1x both mean divide by 16
    always_comb
    begin
        case (sel_i)
            PRE_SEL_DIV1: last = PRE_LAST_DIV1;
            PRE_SEL_DIV4: last = PRE_LAST_DIV4;
            default: last = PRE_LAST_DIV16;
        endcase
    end

    // A clear suppresses the pulse so a register write never races an increment
    assign pulse_o = tick_i && !clr_i && (cnt_q == last);
    assign cnt_o = cnt_q;

    // Divider counter
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || clr_i)
            cnt_q <= 4'h0;
        else if (tick_i)
        begin
            if (cnt_q == last)
                cnt_q <= 4'h0;
            else
                cnt_q <= cnt_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_pre_ratio_gap: assert property (pulse_o |=> (cnt_q == 4'h0))
        else $error("prescaler did not restart after its pulse");
    a_pre_div16_code: assert property ((sel_i[1] && pulse_o) |-> (cnt_q == 4'hF))
        else $error("divide-by-16 pulse at wrong count");

endmodule

// file: pmt_postscaler.sv
module pmt_postscaler
    import pmt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic match_i,
    input wire logic [3:0] sel_i,
    output logic pulse_o,
    output logic [3:0] cnt_o
);

    logic [3:0] cnt_q;

    // Field value n fires on every (n+1)th match
    assign pulse_o = match_i && !clr_i && (cnt_q == sel_i);
    assign cnt_o = cnt_q;

    // Match counter
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || clr_i)
            cnt_q <= 4'h0;
        else if (match_i)
        begin
            if (cnt_q == sel_i)
                cnt_q <= 4'h0;
            else
                cnt_q <= cnt_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_post_advance: assert property ((match_i && !clr_i && cnt_q != sel_i)
        |=> (cnt_q == $past(cnt_q) + 4'h1))
        else $error("postscaler did not advance on a match");
    a_post_ratio: assert property (pulse_o |-> (cnt_q == sel_i))
        else $error("postscaler fired at wrong count");

endmodule

// file: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pmt_pkg::*;

    logic SYS_CLK_I = 1'b0;
    logic RESET_N_I = 1'b0;
    logic [ADDR_W-1:0] REG_ADDR_I = 4'h0;
    logic [DATA_W-1:0] REG_WDATA_I = 8'h00;
    logic REG_WR_I = 1'b0;
    logic REG_RD_I = 1'b0;
    logic [DATA_W-1:0] REG_RDATA_O;
    logic IRQ_O;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] exp_q[$];
    logic [7:0] exp_hd;
    logic rd_seen = 1'b0;
    logic [7:0] per;
    logic [7:0] cnt;
    logic [3:0] post_tab [3];

    pmt_top u_dut (
        .SYS_CLK_I(SYS_CLK_I),
        .RESET_N_I(RESET_N_I),
        .REG_ADDR_I(REG_ADDR_I),
        .REG_WDATA_I(REG_WDATA_I),
        .REG_WR_I(REG_WR_I),
        .REG_RD_I(REG_RD_I),
        .REG_RDATA_O(REG_RDATA_O),
        .IRQ_O(IRQ_O)
    );

    // Free-running 100 MHz clock
    initial
    begin
        forever #5 SYS_CLK_I = ~SYS_CLK_I;
    end

    task automatic check(input bit ok, input string msg);
        total_checks++;
        if (!ok)
        begin
            failures++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One-cycle bus strobes, launched just after a rising edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge SYS_CLK_I);
        REG_WR_I <= 1'b1;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        @(posedge SYS_CLK_I);
        REG_WR_I <= 1'b0;
    endtask

    // The expected data is queued before the strobe so the monitor never runs dry
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge SYS_CLK_I);
        exp_q.push_back(e);
        REG_RD_I <= 1'b1;
        REG_ADDR_I <= a;
        @(posedge SYS_CLK_I);
        REG_RD_I <= 1'b0;
    endtask

    // Waits for a fresh rising interrupt; bounded so a dead timer cannot hang the run
    task automatic wait_irq;
        int n;
        n = 0;
        while (IRQ_O !== 1'b0 && n < 20000)
        begin
            @(negedge SYS_CLK_I);
            n++;
        end
        while (IRQ_O !== 1'b1 && n < 20000)
        begin
            @(negedge SYS_CLK_I);
            n++;
        end
        if (n >= 20000)
            check(1'b0, "interrupt never rose");
    endtask

    // Two rises apart from a cleared flag give the exact event period
    task automatic measure(input logic [7:0] ctl, input logic [7:0] p, input int expc);
        int t0;
        wr(ADDR_PERIOD, p);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CONTROL, ctl);
        wait_irq();
        rd(ADDR_STATUS, 8'h01);
        wait_irq();
        t0 = cyc;
        rd(ADDR_STATUS, 8'h01);
        wait_irq();
        check(cyc - t0 == expc, "interrupt period wrong");
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_STATUS, 8'h01);
    endtask

    // Read data lives only in the cycle after the read edge; zero elsewhere
    always @(posedge SYS_CLK_I)
        rd_seen <= REG_RD_I & RESET_N_I;

    always @(negedge SYS_CLK_I)
    begin
        if (rd_seen)
        begin
            exp_hd = exp_q.pop_front();
            check(REG_RDATA_O === exp_hd, "read data mismatch");
        end
        else if (RESET_N_I)
            check(REG_RDATA_O === 8'h00, "read data not idle");
    end

    // Cycle count doubles as the hang guard
    always @(posedge SYS_CLK_I)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            failures++;
            give_verdict();
        end
    end

    initial
    begin
        void'($urandom(63));
        repeat (3) @(posedge SYS_CLK_I);
        RESET_N_I <= 1'b1;
        rd(ADDR_COUNT, 8'h00);
        rd(ADDR_PERIOD, 8'hFF);
        rd(ADDR_CONTROL, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        rd(4'hF, 8'h00);
        per = 8'($urandom);
        cnt = 8'($urandom);
        wr(ADDR_PERIOD, per);
        wr(ADDR_COUNT, cnt);
        rd(ADDR_PERIOD, per);
        rd(ADDR_COUNT, cnt);
        wr(ADDR_CONTROL, 8'hFB);
        rd(ADDR_CONTROL, 8'h7B);
        rd(ADDR_COUNT, cnt);
        repeat (100) @(posedge SYS_CLK_I);
        rd(ADDR_COUNT, cnt);
        // Flag raised while masked, then exposed by the mask
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_PERIOD, 8'h01);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CONTROL, 8'h04);
        repeat (40) @(posedge SYS_CLK_I);
        wr(ADDR_CONTROL, 8'h00);
        @(negedge SYS_CLK_I);
        check(IRQ_O === 1'b0, "masked interrupt seen");
        wr(ADDR_MASK, 8'h01);
        @(negedge SYS_CLK_I);
        check(IRQ_O === 1'b1, "flag not set");
        repeat (50) @(posedge SYS_CLK_I);
        @(negedge SYS_CLK_I);
        check(IRQ_O === 1'b1, "flag did not hold");
        rd(ADDR_MASK, 8'h01);
        rd(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, 8'h00);
        @(negedge SYS_CLK_I);
        check(IRQ_O === 1'b0, "interrupt stuck");
        // Every prescale code, period 3, postscale 1:1
        for (int p = 0; p < 4; p++)
            measure({5'h01, 2'(p)}, 8'h03, 16 * (p == 0 ? 1 : (p == 1 ? 4 : 16)));
        // Postscale select 1, the maximum 15 and a random ratio at the fastest prescale
        post_tab = '{4'h1, 4'hF, 4'($urandom_range(14, 2))};
        foreach (post_tab[i])
        begin
            per = 8'($urandom_range(7, 1));
            measure({1'b0, post_tab[i], 3'h4}, per, 4 * (per + 1) * (post_tab[i] + 1));
        end
        give_verdict();
    end
endmodule
